// >>> hw/bdm_cfg.svh
// Address map, field positions, reset values and timing counts of the data memory mapper
`ifndef BDM_CFG_SVH
`define BDM_CFG_SVH

`define BDM_ADDR_W        12
`define BDM_BANK_W        4
`define BDM_OFFS_W        8
`define BDM_DATA_W        8
`define BDM_NUM_BANKS     16
`define BDM_IMPL_BANKS    16'hFFFF
`define BDM_SFR_BASE      12'hF40
`define BDM_BANKPTR_ADDR  12'hFE0
`define BDM_BANKPTR_RST   4'h0
`define BDM_FORCED_SPLIT  8'h60
`define BDM_FORCED_LO     4'h0
`define BDM_FORCED_HI     4'hF
`define BDM_DESC_BANK     4'hD
`define BDM_CLK_HZ        10000000
`define BDM_PHASES        4

`endif

// >>> hw/bdm_mapper.sv
// Banked data memory address former and core/USB access arbiter
`include "bdm_cfg.svh"

module bdm_mapper #(
	parameter logic [15:0] IMPL_BANKS = `BDM_IMPL_BANKS,
	parameter int          RAM_DEPTH  = 3904
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_i,
	// Configuration
	input  wire logic                  extended_set_enable_i,
	input  wire logic                  usb_enable_i,
	// Core side, sampled at the operand read edge
	input  wire logic                  core_op_i,
	input  wire logic                  core_rd_i,
	input  wire logic                  core_wr_i,
	input  wire logic                  core_access_i,
	input  wire logic                  core_full_i,
	input  wire logic [7:0]            core_offset_i,
	input  wire bdm_pkg::bdm_addr_t    core_src_i,
	input  wire bdm_pkg::bdm_addr_t    core_dst_i,
	input  wire bdm_pkg::bdm_addr_t    core_index_base_i,
	// Core side, sampled at the result write edge
	input  wire bdm_pkg::bdm_byte_t    core_wdata_i,
	input  wire logic                  load_bank_literal_i,
	input  wire logic [3:0]            load_bank_value_i,
	output bdm_pkg::bdm_phase_t        phase_o,
	output bdm_pkg::bdm_byte_t         core_rdata_o,
	output logic                       core_done_o,
	output logic                       core_wr_dropped_o,
	output logic [7:0]                 bank_pointer_o,
	// USB packet DMA side
	input  wire logic                  usb_req_i,
	input  wire logic                  usb_we_i,
	input  wire bdm_pkg::bdm_addr_t    usb_addr_i,
	input  wire bdm_pkg::bdm_byte_t    usb_wdata_i,
	output logic                       usb_ack_o,
	output logic                       usb_desc_hit_o,
	output bdm_pkg::bdm_byte_t         usb_rdata_o
);
	import bdm_pkg::*;

	bdm_phase_t phase_r;
	logic [3:0] bank_pointer_r;
	bdm_addr_t  src_addr_r;
	bdm_addr_t  dst_addr_r;
	logic       op_pend_r;
	logic       rd_pend_r;
	logic       wr_pend_r;
	logic       core_rd_hit_r;
	logic       core_rd_bp_r;
	bdm_byte_t  core_rdata_r;
	logic       core_done_r;
	logic       core_wr_dropped_r;
	logic       usb_pend_r;
	logic       usb_ack_r;
	logic       usb_rd_hit_r;
	logic       usb_desc_r;
	logic       usb_desc_hit_r;
	bdm_byte_t  usb_rdata_r;

	bdm_addr_t  core_rd_addr;
	bdm_addr_t  core_wr_addr;
	logic       usb_slot;
	logic       usb_take;
	logic       core_rd_take;
	logic       core_wr_take;
	logic       ram_en;
	logic       ram_we;
	bdm_addr_t  ram_addr;
	bdm_byte_t  ram_wdata;
	bdm_byte_t  ram_q;

	// Location holds storage: implemented bank and below the register area
	function automatic logic is_ram(input bdm_addr_t a);
		is_ram = IMPL_BANKS[a[11:8]] && (a < `BDM_SFR_BASE);
	endfunction : is_ram

	// Forced map: low part from bank 0, high part from bank 15
	function automatic bdm_addr_t forced_addr(input logic [7:0] off, input logic ext,
	                                          input bdm_addr_t base);
		if (off >= `BDM_FORCED_SPLIT) begin
			forced_addr = {`BDM_FORCED_HI, off};
		end else if (ext) begin
			// Extended set turns the low part into base plus literal offset
			forced_addr = base + {4'h0, off};
		end else begin
			forced_addr = {`BDM_FORCED_LO, off};
		end
	endfunction : forced_addr

	// Operand address formed from the instruction fields
	always_comb begin
		if (core_full_i) begin
			core_rd_addr = core_src_i;
			core_wr_addr = core_dst_i;
		end else if (core_access_i) begin
			core_rd_addr = {bank_pointer_r, core_offset_i};
			core_wr_addr = {bank_pointer_r, core_offset_i};
		end else begin
			// Bank pointer ignored; 060h-F5Fh can be formed here only through the extended-set base
			core_rd_addr = forced_addr(core_offset_i, extended_set_enable_i,
			                           core_index_base_i);
			core_wr_addr = core_rd_addr;
		end
	end

	// Four-phase sequencer; one clock per phase
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase_r <= PH_FETCH;
		end else begin
			unique case (phase_r)
				PH_FETCH: phase_r <= PH_READ;
				PH_READ:  phase_r <= PH_EXEC;
				PH_EXEC:  phase_r <= PH_WRITE;
				PH_WRITE: phase_r <= PH_FETCH;
			endcase
		end
	end

	// Fixed slot plan: core owns read/write phases, USB the other two
	assign usb_slot     = (phase_r == PH_FETCH) || (phase_r == PH_EXEC);
	assign usb_take     = usb_slot && usb_req_i && usb_enable_i && !usb_ack_r
	                      && !usb_pend_r;
	assign core_rd_take = (phase_r == PH_READ) && core_op_i && core_rd_i;
	assign core_wr_take = (phase_r == PH_WRITE) && op_pend_r && wr_pend_r
	                      && !load_bank_literal_i;

	// Single RAM port steered by phase, so no two requests ever meet
	always_comb begin
		ram_en    = 1'b0;
		ram_we    = 1'b0;
		ram_addr  = 12'h000;
		ram_wdata = 8'h00;
		if (usb_take) begin
			ram_en    = is_ram(usb_addr_i);
			ram_we    = usb_we_i;
			ram_addr  = usb_addr_i;
			ram_wdata = usb_wdata_i;
		end else if (core_rd_take) begin
			ram_en    = is_ram(core_rd_addr);
			ram_addr  = core_rd_addr;
		end else if (core_wr_take) begin
			ram_en    = is_ram(dst_addr_r);
			ram_we    = 1'b1;
			ram_addr  = dst_addr_r;
			ram_wdata = core_wdata_i;
		end
	end

	bdm_ram #(
		.DEPTH (RAM_DEPTH),
		.AW    (`BDM_ADDR_W),
		.DW    (`BDM_DATA_W)
	) u_ram (
		.clk_sys_i (clk_sys_i),
		.en_i      (ram_en),
		.we_i      (ram_we),
		.addr_i    (ram_addr),
		.wdata_i   (ram_wdata),
		.rdata_o   (ram_q)
	);

	// Capture of the instruction's addresses and intent at operand read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			op_pend_r  <= 1'b0;
			rd_pend_r  <= 1'b0;
			wr_pend_r  <= 1'b0;
			src_addr_r <= 12'h000;
			dst_addr_r <= 12'h000;
		end else if (phase_r == PH_READ) begin
			op_pend_r  <= core_op_i;
			rd_pend_r  <= core_op_i && core_rd_i;
			wr_pend_r  <= core_op_i && core_wr_i;
			src_addr_r <= core_rd_addr;
			dst_addr_r <= core_wr_addr;
		end else if (phase_r == PH_WRITE) begin
			op_pend_r  <= 1'b0;
			rd_pend_r  <= 1'b0;
			wr_pend_r  <= 1'b0;
		end
	end

	// Source class remembered so the read can be zeroed or redirected
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			core_rd_hit_r <= 1'b0;
			core_rd_bp_r  <= 1'b0;
		end else if (core_rd_take) begin
			core_rd_hit_r <= is_ram(core_rd_addr);
			core_rd_bp_r  <= (core_rd_addr == `BDM_BANKPTR_ADDR);
		end
	end

	// Operand data valid from the write phase onward
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			core_rdata_r <= 8'h00;
		end else if ((phase_r == PH_EXEC) && rd_pend_r) begin
			if (core_rd_hit_r) begin
				core_rdata_r <= ram_q;
			end else if (core_rd_bp_r) begin
				core_rdata_r <= {4'h0, bank_pointer_r};
			end else begin
				core_rdata_r <= 8'h00;
			end
		end
	end

	// Bank pointer: literal load or a write to its own address
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bank_pointer_r <= `BDM_BANKPTR_RST;
		end else if ((phase_r == PH_WRITE) && load_bank_literal_i) begin
			bank_pointer_r <= load_bank_value_i;
		end else if (core_wr_take && (dst_addr_r == `BDM_BANKPTR_ADDR)) begin
			bank_pointer_r <= core_wdata_i[3:0];
		end
	end

	// Completion every instruction, dropped or not, so flags still update
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			core_done_r       <= 1'b0;
			core_wr_dropped_r <= 1'b0;
		end else begin
			core_done_r       <= (phase_r == PH_WRITE) && op_pend_r;
			core_wr_dropped_r <= core_wr_take && !is_ram(dst_addr_r)
			                     && (dst_addr_r != `BDM_BANKPTR_ADDR);
		end
	end

	// USB request in flight; answer lands two clocks after the slot
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			usb_pend_r   <= 1'b0;
			usb_rd_hit_r <= 1'b0;
			usb_desc_r   <= 1'b0;
		end else begin
			usb_pend_r   <= usb_take;
			if (usb_take) begin
				usb_rd_hit_r <= is_ram(usb_addr_i) && !usb_we_i;
				// Only an enabled engine treats bank 13 as descriptors
				usb_desc_r   <= (usb_addr_i[11:8] == `BDM_DESC_BANK);
			end
		end
	end

	// Acknowledge and read data; ack also holds off the next slot
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			usb_ack_r      <= 1'b0;
			usb_desc_hit_r <= 1'b0;
			usb_rdata_r    <= 8'h00;
		end else begin
			usb_ack_r      <= usb_pend_r;
			usb_desc_hit_r <= usb_pend_r && usb_desc_r;
			if (usb_pend_r) begin
				usb_rdata_r <= usb_rd_hit_r ? ram_q : 8'h00;
			end
		end
	end

	// Outputs straight from flip-flops
	assign phase_o           = phase_r;
	assign core_rdata_o      = core_rdata_r;
	assign core_done_o       = core_done_r;
	assign core_wr_dropped_o = core_wr_dropped_r;
	assign bank_pointer_o    = {4'h0, bank_pointer_r};
	assign usb_ack_o         = usb_ack_r;
	assign usb_desc_hit_o    = usb_desc_hit_r;
	assign usb_rdata_o       = usb_rdata_r;
endmodule : bdm_mapper

// >>> hw/bdm_pkg.sv
// Types shared by the data memory mapper
package bdm_pkg;
	// Quadrature phases of one instruction cycle
	typedef enum logic [1:0] {
		PH_FETCH,
		PH_READ,
		PH_EXEC,
		PH_WRITE
	} bdm_phase_t;

	typedef logic [11:0] bdm_addr_t;
	typedef logic [7:0]  bdm_byte_t;
endpackage : bdm_pkg

// >>> hw/bdm_ram.sv
// Single-port static RAM with registered read, one access per clock
module bdm_ram #(
	parameter int DEPTH = 3904,
	parameter int AW    = 12,
	parameter int DW    = 8
) (
	input  wire logic          clk_sys_i,
	input  wire logic          en_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [DEPTH];

	// Contents are not cleared by reset, as for general RAM
	always_ff @(posedge clk_sys_i) begin
		if (en_i && we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	// Read data valid the cycle after the enable
	always_ff @(posedge clk_sys_i) begin
		if (en_i) begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule : bdm_ram

// >>> tb/bdm_mapper_properties.sv
// Concurrent checks on the data memory mapper top-level ports
module bdm_mapper_properties (
	input wire logic                clk_sys_i,
	input wire logic                rst_i,
	input wire logic                core_op_i,
	input wire logic                load_bank_literal_i,
	input wire logic [3:0]          load_bank_value_i,
	input wire logic                usb_req_i,
	input wire logic                usb_enable_i,
	input wire bdm_pkg::bdm_phase_t phase_o,
	input wire logic                core_done_o,
	input wire logic                core_wr_dropped_o,
	input wire logic [7:0]          bank_pointer_o,
	input wire logic                usb_ack_o,
	input wire logic                usb_desc_hit_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import bdm_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Instruction taken at operand read
	sequence s_op_taken;
		phase_o == PH_READ && core_op_i;
	endsequence
	// Load-bank literal presented two edges later, at result write
	sequence s_load_bank;
		s_op_taken ##2 load_bank_literal_i;
	endsequence
	a_phase_walk: assert property (!$past(rst_i) |-> phase_o == bdm_phase_t'($past(phase_o) + 2'd1))
		else $error("phase did not advance by one");
	a_bank_upper: assert property (bank_pointer_o[7:4] == 4'h0)
		else $error("bank pointer upper bits not zero");
	a_load_bank: assert property (s_load_bank |=> bank_pointer_o == {4'h0, $past(load_bank_value_i)})
		else $error("bank pointer not loaded from literal");
	a_done_single: assert property (s_op_taken |-> ##3 core_done_o)
		else $error("instruction not done within one cycle");
	a_drop_pair: assert property (core_wr_dropped_o |-> core_done_o)
		else $error("dropped write without done");
	a_usb_gate: assert property (usb_ack_o |-> $past(usb_req_i, 2) && $past(usb_enable_i, 2))
		else $error("usb ack without enabled request");
	a_ack_single: assert property (usb_ack_o |=> !usb_ack_o)
		else $error("usb ack longer than one cycle");
	a_desc_pair: assert property (usb_desc_hit_o |-> usb_ack_o)
		else $error("descriptor hit without ack");
endmodule : bdm_mapper_properties

bind bdm_mapper bdm_mapper_properties u_props (.clk_sys_i, .rst_i, .core_op_i, .load_bank_literal_i,
	.load_bank_value_i, .usb_req_i, .usb_enable_i, .phase_o, .core_done_o, .core_wr_dropped_o,
	.bank_pointer_o, .usb_ack_o, .usb_desc_hit_o);

// >>> tb/bdm_mapper_tb_top.sv
// Self-checking bench for the data memory mapper
module bdm_mapper_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import bdm_pkg::*;
	logic       clk, rst, ext_en, usb_en, op, rd_en, wr_en, acc, full, ld, req, uwe, ack, hit;
	logic       done, drop, acked, dropped_seen, hit_seen;
	logic [3:0] ld_val;
	logic [7:0] offs, bp;
	bdm_addr_t  src, dst, ibase, uaddr;
	bdm_byte_t  wd, rdat, uwd, urd, rv, urv;
	bdm_phase_t ph;
	int         err_total, n_compared;

	bdm_mapper dut (.clk_sys_i(clk), .rst_i(rst), .extended_set_enable_i(ext_en),
		.usb_enable_i(usb_en), .core_op_i(op), .core_rd_i(rd_en), .core_wr_i(wr_en),
		.core_access_i(acc), .core_full_i(full), .core_offset_i(offs), .core_src_i(src),
		.core_dst_i(dst), .core_index_base_i(ibase), .core_wdata_i(wd),
		.load_bank_literal_i(ld), .load_bank_value_i(ld_val), .phase_o(ph), .core_rdata_o(rdat),
		.core_done_o(done), .core_wr_dropped_o(drop), .bank_pointer_o(bp), .usb_req_i(req),
		.usb_we_i(uwe), .usb_addr_i(uaddr), .usb_wdata_i(uwd), .usb_ack_o(ack),
		.usb_desc_hit_o(hit), .usb_rdata_o(urd));
	bdm_usb_dma_model usb (.clk_sys_i(clk), .usb_ack_i(ack), .usb_rdata_i(urd), .usb_req_o(req),
		.usb_we_o(uwe), .usb_addr_o(uaddr), .usb_wdata_o(uwd));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Descriptor hits are single pulses, so latch them for a later look
	always @(posedge clk) if (hit) hit_seen <= 1'b1;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk
	// One instruction cycle: access bit, full move, write, load-bank, offset, src, dst, data
	task automatic cop(input logic a, f, w, l, input logic [7:0] o, input bdm_addr_t s, d,
		input bdm_byte_t v);
		for (int n = 0; n < 8 && ph !== PH_READ; n++) @(negedge clk);
		{op, acc, full, wr_en, rd_en, ld, ld_val, offs, src, dst, wd} = {1'b1, a, f, w, 1'b1, l, v[3:0], o, s, d, v};
		@(negedge clk);
		op = 1'b0;
		@(negedge clk);
		rv = rdat;
		// A move writes back the byte it has just read
		if (f) wd = rv;
		@(negedge clk);
		chk("done", 8'h01, {7'h0, done});
		dropped_seen = drop;
		ld = 1'b0;
	endtask : cop
	task automatic rd_full(input bdm_addr_t a);
		cop(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, a, a, 8'h00);
	endtask : rd_full
	task automatic mv_full(input bdm_addr_t s, d);
		cop(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, s, d, 8'h00);
	endtask : mv_full
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		{rst, ext_en, usb_en, op, rd_en, wr_en, acc, full, ld, ld_val, offs} = {9'h100, 12'h000};
		{src, dst, ibase, wd, err_total, n_compared, hit_seen} = '0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		chk("bank reset", 8'h00, bp);
		cop(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 12'h000, 12'h000, 8'hF5);
		chk("bank load", 8'h05, bp);
		cop(1'b1, 1'b0, 1'b1, 1'b0, 8'h34, 12'h000, 12'h000, 8'hA9);
		rd_full(12'h534);
		chk("banked", 8'hA9, rv);
		mv_full(12'h534, 12'h777);
		rd_full(12'h777);
		chk("full move", 8'hA9, rv);
		cop(1'b0, 1'b0, 1'b1, 1'b0, 8'h10, 12'h000, 12'h000, 8'h3C);
		rd_full(12'h010);
		chk("forced low", 8'h3C, rv);
		cop(1'b0, 1'b0, 1'b0, 1'b0, 8'hE0, 12'h000, 12'h000, 8'h00);
		chk("forced high", 8'h05, rv);
		mv_full(12'h534, 12'hFE0);
		chk("bank upper", 8'h09, bp);
		rd_full(12'hF50);
		chk("unimpl read", 8'h00, rv);
		mv_full(12'h534, 12'hF50);
		chk("drop", 8'h01, {7'h0, dropped_seen});
		mv_full(12'h534, 12'hEC0);
		cop(1'b0, 1'b0, 1'b0, 1'b0, 8'hC0, 12'h000, 12'h000, 8'h00);
		chk("forced hole", 8'h00, rv);
		{ext_en, ibase} = {1'b1, 12'h200};
		cop(1'b0, 1'b0, 1'b1, 1'b0, 8'h10, 12'h000, 12'h000, 8'h6B);
		ext_en = 1'b0;
		rd_full(12'h210);
		chk("ext forced", 8'h6B, rv);
		rd_full(12'h010);
		chk("ext untouched", 8'h3C, rv);
		usb_en = 1'b1;
		usb.xfer(0, 1'b1, 12'hD10, 8'h5A, urv, acked);
		chk("usb ack", 8'h01, {7'h0, acked});
		chk("desc hit", 8'h01, {7'h0, hit_seen});
		cop(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 12'h000, 12'h000, 8'h0D);
		cop(1'b1, 1'b0, 1'b0, 1'b0, 8'h10, 12'h000, 12'h000, 8'h00);
		chk("usb to core", 8'h5A, rv);
		usb.xfer(3, 1'b0, 12'h534, 8'h00, urv, acked);
		chk("usb read", 8'hA9, urv);
		fork
			usb.xfer(0, 1'b1, 12'hD30, 8'h44, urv, acked);
			cop(1'b1, 1'b0, 1'b1, 1'b0, 8'h31, 12'h000, 12'h000, 8'h55);
		join
		rd_full(12'hD30);
		chk("shared usb", 8'h44, rv);
		rd_full(12'hD31);
		chk("shared core", 8'h55, rv);
		usb_en = 1'b0;
		usb.xfer(0, 1'b1, 12'hD20, 8'h77, urv, acked);
		chk("usb off", 8'h00, {7'h0, acked});
		cop(1'b1, 1'b0, 1'b1, 1'b0, 8'h20, 12'h000, 12'h000, 8'h11);
		rd_full(12'hD20);
		chk("bank13 ram", 8'h11, rv);
		complete_run();
	end
endmodule : bdm_mapper_tb_top

// >>> tb/bdm_usb_dma_model.sv
// Behavioural USB packet DMA master on the mapper's USB port
module bdm_usb_dma_model (
	input  wire logic               clk_sys_i,
	input  wire logic               usb_ack_i,
	input  wire bdm_pkg::bdm_byte_t usb_rdata_i,
	output logic                    usb_req_o,
	output logic                    usb_we_o,
	output bdm_pkg::bdm_addr_t      usb_addr_o,
	output bdm_pkg::bdm_byte_t      usb_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import bdm_pkg::*;
	initial begin
		{usb_req_o, usb_we_o, usb_addr_o, usb_wdata_o} = '0;
	end
	// One byte by DMA; idle lines show the inverse so a stale copy never passes
	task automatic xfer(input int dly, input logic we, input bdm_addr_t a, input bdm_byte_t wd,
		output bdm_byte_t rd, output logic acked);
		repeat (dly + 1) @(negedge clk_sys_i);
		{usb_req_o, usb_we_o, usb_addr_o, usb_wdata_o} = {1'b1, we, a, wd};
		acked = 1'b0;
		rd = 8'h00;
		// Ack looked at mid-cycle where it is settled; release after its closing edge
		for (int n = 0; n < 12 && !acked; n++) begin
			@(negedge clk_sys_i);
			acked = usb_ack_i;
			rd = usb_rdata_i;
		end
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		{usb_req_o, usb_we_o, usb_addr_o, usb_wdata_o} = {1'b0, ~we, ~a, ~wd};
	endtask : xfer
endmodule : bdm_usb_dma_model
